// [verilog/host_port_consts.svh]
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH
// Operation
// - The default VID, resetting to 0x001, replaces the VID of untagged or null-VID ingress frames and is the lookup VID.
// - Untagged host-port frames carry the default tag, which is also what egress tagging inserts for them.
// - The default tag keeps user priority in bits 15-13 and CFI in bit 12, both resetting to zero and writable.
// - The default VID sits in bits 11-0 of the default tag register.
// - Ingress limit mode 00 counts all frames, 01 broadcast/multicast/flooded unicast, 10 broadcast/multicast, 11 broadcast only; egress counts all.
// - With the gap bit set, 12 gap bytes per frame join ingress and egress byte accounting, otherwise none.
// - With the preamble bit set, 8 preamble bytes per frame join ingress and egress accounting, otherwise none.
// - The low ingress rate register holds priority 1 in bits 14-8 and priority 0 in bits 6-0, bits 15 and 7 reserved.
// - The high ingress rate register holds priority 3 in bits 14-8 and priority 2 in bits 6-0.
// - Ingress frames of a class counted by the limit mode and above the rate set for their priority are dropped.
// - A rate code of zero, the reset value, means full line rate with no limiting.
// - Bit 7 of the low egress rate register enables egress limiting and resets to zero.
// - The low egress rate register holds priority 1 in bits 14-8 and priority 0 in bits 6-0; excess frames drop.
// - The high egress rate register holds priority 3 in bits 14-8 and priority 2 in bits 6-0, bits 15 and 7 reserved.

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_DEFAULT_TAG 8'hA0
`define OFS_LIMIT_CTRL 8'hA2
`define OFS_INGRESS_LO 8'hA4
`define OFS_INGRESS_HI 8'hA6
`define OFS_EGRESS_LO 8'hA8
`define OFS_EGRESS_HI 8'hAA

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define TAG_PRIO_HI 15
`define TAG_PRIO_LO 13
`define TAG_CFI_BIT 12
`define TAG_VID_HI 11
`define TAG_VID_LO 0
`define TAG_RST 16'h0001
`define MODE_HI 3
`define MODE_LO 2
`define GAP_BIT 1
`define PRE_BIT 0
`define RATE_HI_MSB 14
`define RATE_HI_LSB 8
`define RATE_LO_MSB 6
`define RATE_LO_LSB 0
`define EGR_EN_BIT 7
`define RATE_RST 7'h00
`define VID_NULL 12'h000

// ---------------------------------------------------------------
// accounting and timing
// ---------------------------------------------------------------
`define GAP_BYTES 12
`define PRE_BYTES 8
`define SYS_CLK_MHZ 20
`define WINDOW_US 1000
`define BYTES_PER_CODE 125
`endif

// [verilog/host_port_pkg.sv]
package host_port_pkg;
  typedef logic [11:0] vid_t;
  typedef logic [6:0] rate_code_t;
  typedef logic [15:0] reg_word_t;
  typedef enum logic [1:0] {LIM_ALL, LIM_BMF, LIM_BM, LIM_B} limit_mode_t;
endpackage : host_port_pkg

// [verilog/rate_meter.sv]
`timescale 1ns/100ps
`include "host_port_consts.svh"
module rate_meter
#(
  parameter int CNT_W = 24
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic window_tick,
  input wire logic charge,
  input wire logic limit_on,
  input wire logic [CNT_W-1:0] bytes,
  input wire logic [CNT_W-1:0] threshold,
  output logic over
);
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] base;
  logic [CNT_W:0] sum;

  // a new window starts from zero even for the frame that opens it
  assign base = window_tick ? '0 : count_r;
  assign sum = {1'b0, base} + {1'b0, bytes};
  assign over = limit_on && (sum > {1'b0, threshold});

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      count_r <= '0;
    else if (charge && !over)
      count_r <= sum[CNT_W-1:0];
    else if (window_tick)
      count_r <= '0;
  end
endmodule : rate_meter

// [verilog/host_port_tag_rate_regs.sv]
`timescale 1ns/100ps
`include "host_port_consts.svh"
module host_port_tag_rate_regs
  import host_port_pkg::*;
#(
  parameter int WINDOW_CYCLES = `WINDOW_US * `SYS_CLK_MHZ,
  parameter int BYTES_PER_CODE = `BYTES_PER_CODE,
  parameter int LEN_W = 11,
  parameter int CNT_W = 24
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic ing_req,
  input wire logic ing_tagged,
  input wire logic [11:0] ing_vid,
  input wire logic [2:0] ing_prio,
  input wire logic ing_cfi,
  input wire logic [1:0] ing_qprio,
  input wire logic ing_bcast,
  input wire logic ing_mcast,
  input wire logic ing_flood,
  input wire logic [LEN_W-1:0] ing_len,
  output logic ing_done,
  output logic ing_drop,
  output logic [11:0] ing_vid_out,
  output logic [2:0] ing_prio_out,
  output logic ing_cfi_out,
  input wire logic egr_req,
  input wire logic egr_untagged,
  input wire logic [1:0] egr_qprio,
  input wire logic [LEN_W-1:0] egr_len,
  output logic egr_done,
  output logic egr_drop,
  output logic egr_insert_tag,
  output logic [15:0] egr_tag_out
);
  if (WINDOW_CYCLES < 2 || BYTES_PER_CODE < 1 || LEN_W < 1 ||
      CNT_W < LEN_W + 8)
  begin : g_bad_params
    $error("host_port_tag_rate_regs: bad parameters");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [CNT_W-1:0] code_budget(input rate_code_t c);
    code_budget = CNT_W'(c * BYTES_PER_CODE);
  endfunction : code_budget

  function automatic logic [CNT_W-1:0] frame_bytes(
    input logic [LEN_W-1:0] len, input logic gap, input logic pre);
    logic [CNT_W-1:0] b;
    b = CNT_W'(len);
    if (gap)
      b = b + CNT_W'(`GAP_BYTES);
    if (pre)
      b = b + CNT_W'(`PRE_BYTES);
    frame_bytes = b;
  endfunction : frame_bytes

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [15:0] tag_r;
  limit_mode_t mode_r;
  logic gap_r;
  logic pre_r;
  rate_code_t irate_r [4];
  rate_code_t erate_r [4];
  logic egr_en_r;
  logic [15:0] rd_nxt;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      tag_r <= `TAG_RST;
    else if (reg_wr && reg_addr == `OFS_DEFAULT_TAG)
      tag_r <= reg_wdata;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      mode_r <= LIM_ALL;
      gap_r <= 1'b0;
      pre_r <= 1'b0;
    end
    else if (reg_wr && reg_addr == `OFS_LIMIT_CTRL)
    begin
      mode_r <= limit_mode_t'(reg_wdata[`MODE_HI:`MODE_LO]);
      gap_r <= reg_wdata[`GAP_BIT];
      pre_r <= reg_wdata[`PRE_BIT];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 4; i++)
        irate_r[i] <= `RATE_RST;
    end
    else if (reg_wr && reg_addr == `OFS_INGRESS_LO)
    begin
      irate_r[1] <= reg_wdata[`RATE_HI_MSB:`RATE_HI_LSB];
      irate_r[0] <= reg_wdata[`RATE_LO_MSB:`RATE_LO_LSB];
    end
    else if (reg_wr && reg_addr == `OFS_INGRESS_HI)
    begin
      irate_r[3] <= reg_wdata[`RATE_HI_MSB:`RATE_HI_LSB];
      irate_r[2] <= reg_wdata[`RATE_LO_MSB:`RATE_LO_LSB];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 4; i++)
        erate_r[i] <= `RATE_RST;
      egr_en_r <= 1'b0;
    end
    else if (reg_wr && reg_addr == `OFS_EGRESS_LO)
    begin
      erate_r[1] <= reg_wdata[`RATE_HI_MSB:`RATE_HI_LSB];
      egr_en_r <= reg_wdata[`EGR_EN_BIT];
      erate_r[0] <= reg_wdata[`RATE_LO_MSB:`RATE_LO_LSB];
    end
    else if (reg_wr && reg_addr == `OFS_EGRESS_HI)
    begin
      erate_r[3] <= reg_wdata[`RATE_HI_MSB:`RATE_HI_LSB];
      erate_r[2] <= reg_wdata[`RATE_LO_MSB:`RATE_LO_LSB];
    end
  end

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  // reserved bits are never stored, so they cannot read back as one
  always_comb
  begin
    rd_nxt = 16'h0000;
    case (reg_addr)
      `OFS_DEFAULT_TAG: rd_nxt = tag_r;
      `OFS_LIMIT_CTRL: rd_nxt = {12'h000, mode_r, gap_r, pre_r};
      `OFS_INGRESS_LO: rd_nxt = {1'b0, irate_r[1], 1'b0, irate_r[0]};
      `OFS_INGRESS_HI: rd_nxt = {1'b0, irate_r[3], 1'b0, irate_r[2]};
      `OFS_EGRESS_LO: rd_nxt = {1'b0, erate_r[1], egr_en_r, erate_r[0]};
      `OFS_EGRESS_HI: rd_nxt = {1'b0, erate_r[3], 1'b0, erate_r[2]};
      default: rd_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rd_nxt;
    else
      reg_rdata <= 16'h0000;
  end

  // ---------------------------------------------------------------
  // measurement window
  // ---------------------------------------------------------------
  logic [31:0] win_cnt_r;
  logic window_tick;

  assign window_tick = (win_cnt_r == 32'(WINDOW_CYCLES - 1));

  always_ff @(posedge sys_clk)
  begin
    if (srst || window_tick)
      win_cnt_r <= 32'h00000000;
    else
      win_cnt_r <= win_cnt_r + 32'h00000001;
  end

  // ---------------------------------------------------------------
  // classification and meters
  // ---------------------------------------------------------------
  logic ing_untag;
  logic ing_counted;
  logic [CNT_W-1:0] ing_bytes;
  logic [CNT_W-1:0] egr_bytes;
  logic [7:0] over_vec;

  // a tagged frame with VID zero keeps its priority, takes our VID
  assign ing_untag = !ing_tagged || ing_vid == `VID_NULL;

  always_comb
  begin
    case (mode_r)
      LIM_ALL: ing_counted = 1'b1;
      LIM_BMF: ing_counted = ing_bcast || ing_mcast || ing_flood;
      LIM_BM: ing_counted = ing_bcast || ing_mcast;
      LIM_B: ing_counted = ing_bcast;
      default: ing_counted = 1'b1;
    endcase
  end

  assign ing_bytes = frame_bytes(ing_len, gap_r, pre_r);
  assign egr_bytes = frame_bytes(egr_len, gap_r, pre_r);

  // one meter per priority and direction; meters 0-3 ingress
  for (genvar g = 0; g < 8; g++)
  begin : g_meter
    logic chg;
    logic lim;
    logic [CNT_W-1:0] byt;
    logic [CNT_W-1:0] thr;
    if (g < 4)
    begin : g_in
      assign chg = ing_req && ing_counted && ing_qprio == 2'(g);
      assign lim = irate_r[g] != `RATE_RST;
      assign byt = ing_bytes;
      assign thr = code_budget(irate_r[g]);
    end
    else
    begin : g_eg
      assign chg = egr_req && egr_qprio == 2'(g - 4);
      assign lim = egr_en_r && erate_r[g-4] != `RATE_RST;
      assign byt = egr_bytes;
      assign thr = code_budget(erate_r[g-4]);
    end
    rate_meter #(.CNT_W(CNT_W)) u_meter (
      .sys_clk(sys_clk),
      .srst(srst),
      .window_tick(window_tick),
      .charge(chg),
      .limit_on(lim),
      .bytes(byt),
      .threshold(thr),
      .over(over_vec[g])
    );
  end

  // ---------------------------------------------------------------
  // ingress answer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ing_done <= 1'b0;
      ing_drop <= 1'b0;
      ing_vid_out <= `VID_NULL;
      ing_prio_out <= 3'h0;
      ing_cfi_out <= 1'b0;
    end
    else
    begin
      ing_done <= ing_req;
      ing_drop <= ing_req && ing_counted && over_vec[ing_qprio];
      if (ing_req)
      begin
        ing_vid_out <= ing_untag ? tag_r[`TAG_VID_HI:`TAG_VID_LO]
                                 : ing_vid;
        ing_prio_out <= ing_tagged ? ing_prio
                                   : tag_r[`TAG_PRIO_HI:`TAG_PRIO_LO];
        ing_cfi_out <= ing_tagged ? ing_cfi : tag_r[`TAG_CFI_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // egress answer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      egr_done <= 1'b0;
      egr_drop <= 1'b0;
      egr_insert_tag <= 1'b0;
      egr_tag_out <= `TAG_RST;
    end
    else
    begin
      egr_done <= egr_req;
      egr_drop <= egr_req && over_vec[4 + {1'b0, egr_qprio}];
      egr_insert_tag <= egr_req && egr_untagged;
      if (egr_req)
        egr_tag_out <= tag_r;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence tag_write_s;
    reg_wr && reg_addr == `OFS_DEFAULT_TAG;
  endsequence

  sequence tag_read_s;
    reg_rd && reg_addr == `OFS_DEFAULT_TAG;
  endsequence

  tag_readback_a: assert property (
    tag_write_s ##1 tag_read_s |=> reg_rdata == $past(reg_wdata, 2))
    else $error("default tag readback wrong");

  untag_vid_a: assert property (
    ing_req && ing_untag |=>
    ing_done && ing_vid_out == $past(tag_r[`TAG_VID_HI:`TAG_VID_LO]))
    else $error("default vid not applied");

  untag_prio_a: assert property (
    ing_req && !ing_tagged |=>
    ing_prio_out == $past(tag_r[`TAG_PRIO_HI:`TAG_PRIO_LO]))
    else $error("default priority not applied");

  egr_tag_a: assert property (
    egr_req && egr_untagged |=> egr_insert_tag && egr_tag_out == $past(tag_r))
    else $error("egress tag not inserted");

  mode_skip_a: assert property (
    ing_req && mode_r == LIM_B && !ing_bcast |=> !ing_drop)
    else $error("uncounted frame dropped");

  zero_code_a: assert property (
    ing_req && irate_r[ing_qprio] == `RATE_RST |=> !ing_drop)
    else $error("zero code limited traffic");

  egr_disabled_a: assert property (
    egr_req && !egr_en_r |=> egr_done && !egr_drop)
    else $error("egress limited while disabled");

  big_frame_a: assert property (
    ing_req && ing_counted && irate_r[ing_qprio] != `RATE_RST &&
    ing_bytes > code_budget(irate_r[ing_qprio]) |=> ing_drop)
    else $error("oversize frame not dropped");

  ctrl_reserved_a: assert property (
    reg_rd && reg_addr == `OFS_LIMIT_CTRL |=> reg_rdata[15:4] == 12'h000)
    else $error("reserved bits read nonzero");
endmodule : host_port_tag_rate_regs

// [tb/host_port_tag_rate_regs_test.sv]
`timescale 1ns/100ps
module host_port_tag_rate_regs_test;
  import host_port_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and wiring
  // ---------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic ing_req = 1'b0, ing_tagged = 1'b0, ing_cfi = 1'b0;
  logic [11:0] ing_vid = 12'h000;
  logic [2:0] ing_prio = 3'h0;
  logic [1:0] ing_qprio = 2'h0, egr_qprio = 2'h0;
  logic ing_bcast = 1'b0, ing_mcast = 1'b0, ing_flood = 1'b0;
  logic [10:0] ing_len = 11'h000, egr_len = 11'h000;
  logic ing_done, ing_drop, ing_cfi_out;
  logic [11:0] ing_vid_out;
  logic [2:0] ing_prio_out;
  logic egr_req = 1'b0, egr_untagged = 1'b0;
  logic egr_done, egr_drop, egr_insert_tag;
  logic [15:0] egr_tag_out;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;

  // short window keeps each metering test inside one window
  host_port_tag_rate_regs #(.WINDOW_CYCLES(200), .BYTES_PER_CODE(125)) DUT
  (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ing_req(ing_req), .ing_tagged(ing_tagged),
    .ing_vid(ing_vid), .ing_prio(ing_prio), .ing_cfi(ing_cfi),
    .ing_qprio(ing_qprio), .ing_bcast(ing_bcast), .ing_mcast(ing_mcast),
    .ing_flood(ing_flood), .ing_len(ing_len), .ing_done(ing_done),
    .ing_drop(ing_drop), .ing_vid_out(ing_vid_out),
    .ing_prio_out(ing_prio_out), .ing_cfi_out(ing_cfi_out),
    .egr_req(egr_req), .egr_untagged(egr_untagged), .egr_qprio(egr_qprio),
    .egr_len(egr_len), .egr_done(egr_done), .egr_drop(egr_drop),
    .egr_insert_tag(egr_insert_tag), .egr_tag_out(egr_tag_out)
  );

  always #25 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic do_reset();
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data land at the edge that samples the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("read %h", a), exp, reg_rdata);
  endtask : rd_chk

  // write then read back on the very next cycle, no idle gap
  task automatic wr_rd_chk(input logic [7:0] a, input logic [15:0] d,
                           input logic [15:0] exp);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("read %h", a), exp, reg_rdata);
  endtask : wr_rd_chk

  // cls is {broadcast, multicast, flooded}
  task automatic ing(input logic tg, input logic [11:0] v,
                     input logic [2:0] p, input logic c, input logic [1:0] q,
                     input logic [2:0] cls, input logic [10:0] len,
                     input logic exp_drop);
    @(posedge sys_clk);
    ing_req <= 1'b1;
    ing_tagged <= tg;
    ing_vid <= v;
    ing_prio <= p;
    ing_cfi <= c;
    ing_qprio <= q;
    {ing_bcast, ing_mcast, ing_flood} <= cls;
    ing_len <= len;
    @(posedge sys_clk);
    ing_req <= 1'b0;
    #1;
    chk("ingress done", 16'h0001, {15'h0000, ing_done});
    chk("ingress drop", {15'h0000, exp_drop}, {15'h0000, ing_drop});
  endtask : ing

  task automatic egr(input logic un, input logic [1:0] q,
                     input logic [10:0] len, input logic exp_drop);
    @(posedge sys_clk);
    egr_req <= 1'b1;
    egr_untagged <= un;
    egr_qprio <= q;
    egr_len <= len;
    @(posedge sys_clk);
    egr_req <= 1'b0;
    #1;
    chk("egress done", 16'h0001, {15'h0000, egr_done});
    chk("egress drop", {15'h0000, exp_drop}, {15'h0000, egr_drop});
    chk("egress insert", {15'h0000, un}, {15'h0000, egr_insert_tag});
  endtask : egr

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    do_reset();
    #1;
    chk("egress tag", 16'h0001, egr_tag_out);
    rd_chk(8'hA0, 16'h0001);
    rd_chk(8'hA2, 16'h0000);
    rd_chk(8'hA4, 16'h0000);
    rd_chk(8'hA6, 16'h0000);
    rd_chk(8'hA8, 16'h0000);
    rd_chk(8'hAA, 16'h0000);
    @(posedge sys_clk);
    #1;
    chk("idle read data", 16'h0000, reg_rdata);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    logic [7:0] adr [6] = '{8'hA0, 8'hA2, 8'hA4, 8'hA6, 8'hA8, 8'hAA};
    logic [15:0] msk [6] = '{16'hFFFF, 16'h000F, 16'h7F7F, 16'h7F7F,
                             16'h7FFF, 16'h7F7F};
    for (int i = 0; i < 6; i++)
    begin
      wr_rd_chk(adr[i], 16'hFFFF, msk[i]);
    end
    wr(8'hAC, 16'hFFFF);
    rd_chk(8'hAC, 16'h0000);
    $display("test register access done");
  endtask : t_regs

  task automatic t_tagging();
    do_reset();
    wr(8'hA0, 16'hB123);
    ing(1'b0, 12'h456, 3'h2, 1'b0, 2'h0, 3'b000, 11'd64, 1'b0);
    chk("vid untagged", 16'h0123, {4'h0, ing_vid_out});
    chk("prio cfi untagged", 16'h000B,
        {12'h000, ing_prio_out, ing_cfi_out});
    ing(1'b1, 12'h000, 3'h2, 1'b0, 2'h0, 3'b000, 11'd64, 1'b0);
    chk("vid null", 16'h0123, {4'h0, ing_vid_out});
    chk("prio cfi null", 16'h0004,
        {12'h000, ing_prio_out, ing_cfi_out});
    ing(1'b1, 12'h456, 3'h2, 1'b0, 2'h0, 3'b000, 11'd64, 1'b0);
    chk("vid tagged", 16'h0456, {4'h0, ing_vid_out});
    egr(1'b1, 2'h0, 11'd64, 1'b0);
    chk("egress tag", 16'hB123, egr_tag_out);
    egr(1'b0, 2'h0, 11'd64, 1'b0);
    $display("test tagging done");
  endtask : t_tagging

  task automatic t_limits();
    do_reset();
    ing(1'b0, 12'h0, 3'h0, 1'b0, 2'h0, 3'b000, 11'd2000, 1'b0);
    ing(1'b0, 12'h0, 3'h0, 1'b0, 2'h0, 3'b000, 11'd2000, 1'b0);
    // unlimited frames still load the meter: start a clean window
    do_reset();
    wr(8'hA4, 16'h0101);
    wr(8'hA6, 16'h0101);
    ing(1'b0, 12'h0, 3'h0, 1'b0, 2'h0, 3'b000, 11'd125, 1'b0);
    ing(1'b0, 12'h0, 3'h0, 1'b0, 2'h0, 3'b000, 11'd1, 1'b1);
    wr(8'hA2, 16'h0002);
    ing(1'b0, 12'h0, 3'h0, 1'b0, 2'h1, 3'b000, 11'd114, 1'b1);
    ing(1'b0, 12'h0, 3'h0, 1'b0, 2'h1, 3'b000, 11'd113, 1'b0);
    wr(8'hA2, 16'h0001);
    ing(1'b0, 12'h0, 3'h0, 1'b0, 2'h2, 3'b000, 11'd118, 1'b1);
    ing(1'b0, 12'h0, 3'h0, 1'b0, 2'h2, 3'b000, 11'd117, 1'b0);
    wr(8'hA2, 16'h0003);
    ing(1'b0, 12'h0, 3'h0, 1'b0, 2'h3, 3'b000, 11'd106, 1'b1);
    ing(1'b0, 12'h0, 3'h0, 1'b0, 2'h3, 3'b000, 11'd105, 1'b0);
    $display("test ingress limits done");
  endtask : t_limits

  task automatic t_modes();
    // expected drop per class: unicast, flooded, multicast, broadcast
    logic [3:0] hit [4] = '{4'b1111, 4'b0111, 4'b0011, 4'b0001};
    logic [2:0] cls [4] = '{3'b000, 3'b001, 3'b010, 3'b100};
    do_reset();
    wr(8'hA4, 16'h0001);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'hA2, {12'h000, m[1:0], 2'b00});
      for (int k = 0; k < 4; k++)
        ing(1'b0, 12'h0, 3'h0, 1'b0, 2'h0, cls[k], 11'd200,
            hit[m][3-k]);
    end
    $display("test limit modes done");
  endtask : t_modes

  task automatic t_egress();
    do_reset();
    wr(8'hA2, 16'h000C);
    wr(8'hA8, 16'h0001);
    egr(1'b0, 2'h0, 11'd200, 1'b0);
    wr(8'hA8, 16'h0081);
    egr(1'b0, 2'h0, 11'd200, 1'b1);
    wr(8'hAA, 16'h0100);
    egr(1'b0, 2'h3, 11'd200, 1'b1);
    egr(1'b0, 2'h2, 11'd200, 1'b0);
    $display("test egress limits done");
  endtask : t_egress

  initial
  begin
    t_reset();
    t_regs();
    t_tagging();
    t_limits();
    t_modes();
    t_egress();
    give_verdict();
  end
endmodule : host_port_tag_rate_regs_test
